// ===== core/supply_fault_status_dump.sv
// Supply monitor sequence and 24-flag status dump with an APB register slave.
module supply_fault_status_dump
	import dump_pkg::*;
#(
	parameter int unsigned START_DELAY = dump_pkg::START_DELAY_CYC
) (
	input  wire logic                          clock,
	input  wire logic                          arst_n,
	input  wire dump_pkg::apb_req_t            apb_req,
	output dump_pkg::apb_rsp_t                 apb_rsp,
	output logic                               irq,
	input  wire logic                          analog_ready,
	input  wire logic                          window_good,
	input  wire logic [dump_pkg::N_FLAGS-1:0]  monitor_flags,
	output logic                               power_good_indicator_n,
	output logic                               dump_clock,
	output logic [dump_pkg::BUS_W-1:0]         status_bus,
	output logic                               capture_strobe
);
	import dump_pkg::*;

	// -----------------------------------------------------------------
	// Pin synchronisers
	// -----------------------------------------------------------------
	logic [N_FLAGS+1:0] pins_s;
	logic               ready_s;
	logic               good_s;
	logic [N_FLAGS-1:0] flags_s;

	sync_2ff #(
		.WIDTH(N_FLAGS + 2)
	) u_pin_sync (
		.clock    (clock),
		.arst_n   (arst_n),
		.async_in ({analog_ready, window_good, monitor_flags}),
		.sync_out (pins_s)
	);

	assign ready_s = pins_s[N_FLAGS+1];
	// The comparator outside applies the 2.0 V and 3.0 V trip points.
	assign good_s  = pins_s[N_FLAGS];
	assign flags_s = pins_s[N_FLAGS-1:0];

	// -----------------------------------------------------------------
	// Dump clock generation
	// -----------------------------------------------------------------
	logic [4:0] div_q;
	logic       dump_tick;

	assign dump_tick = (div_q == 5'(DUMP_HALF_CYC - 1)) && !dump_clock;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			div_q      <= 5'h00;
			dump_clock <= 1'b0;
		end else if (div_q == 5'(DUMP_HALF_CYC - 1)) begin
			div_q      <= 5'h00;
			dump_clock <= !dump_clock;
		end else begin
			div_q <= div_q + 5'h01;
		end
	end

	// -----------------------------------------------------------------
	// Main monitoring sequence
	// -----------------------------------------------------------------
	seq_state_t state_q;
	logic       timer_start;
	logic       timer_done;
	logic       seq_request;
	logic       force_dump;
	logic       dump_request_n_q;
	logic [2:0] counter_q;

	assign timer_start = (state_q == S_WAIT_READY) && ready_s;
	assign seq_request = (state_q == S_MONITOR) && !good_s;

	delay_timer #(
		.WIDTH(TIMER_W)
	) u_start_timer (
		.clock  (clock),
		.arst_n (arst_n),
		.start  (timer_start),
		.load   (TIMER_W'(START_DELAY)),
		.done   (timer_done)
	);

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= S_WAIT_READY;
		end else begin
			unique case (state_q)
				S_WAIT_READY: if (ready_s) state_q <= S_DELAY;
				S_DELAY:      if (timer_done) state_q <= S_WAIT_GOOD;
				S_WAIT_GOOD:  if (good_s) state_q <= S_MONITOR;
				S_MONITOR:    if (!good_s) state_q <= S_WAIT_GOOD;
			endcase
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			power_good_indicator_n <= 1'b1;
		end else if (state_q == S_WAIT_READY || state_q == S_DELAY) begin
			power_good_indicator_n <= 1'b1;
		end else if (state_q == S_WAIT_GOOD && good_s) begin
			power_good_indicator_n <= 1'b0;
		end else if (seq_request) begin
			power_good_indicator_n <= 1'b1;
		end
	end

	// A new request wins over the release at count 2 for one cycle only; the count is still 2, so it starts no new dump.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			dump_request_n_q <= 1'b1;
		end else if (seq_request || force_dump) begin
			dump_request_n_q <= 1'b0;
		end else if (counter_q == CNT_LAST) begin
			dump_request_n_q <= 1'b1;
		end
	end

	// -----------------------------------------------------------------
	// Dump counter and status decode
	// -----------------------------------------------------------------
	logic [2:0]       counter_d;
	logic [2:0]       slot;
	logic [BUS_W-1:0] bus_d;

	always_comb begin
		if (dump_request_n_q) begin
			counter_d = CNT_HOLD;
		end else if (dump_tick) begin
			counter_d = counter_q + 3'h1;
		end else begin
			counter_d = counter_q;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			counter_q <= CNT_HOLD;
		end else begin
			counter_q <= counter_d;
		end
	end

	// Slot k of the dump is count 4+k; bit g carries flag 6g+k.
	assign slot = counter_d - CNT_FIRST;

	always_comb begin
		bus_d = '0;
		if (counter_d != CNT_HOLD && counter_d != CNT_LAST) begin
			for (int g = 0; g < BUS_W; g++) begin
				bus_d[g] = flags_s[DUMP_SLOTS * g + 32'(slot)];
			end
		end
	end

	// The bus is registered from the next count so that it tracks the
	// counter exactly while still coming straight from a flip-flop.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			status_bus     <= '0;
			capture_strobe <= 1'b0;
		end else begin
			status_bus     <= bus_d;
			capture_strobe <= counter_d[2];
		end
	end

	// -----------------------------------------------------------------
	// APB slave and interrupts
	// -----------------------------------------------------------------
	logic       setup;
	logic       wr_acc;
	logic       mapped;
	logic [1:0] irq_status_q;
	logic [1:0] irq_mask_q;
	logic [1:0] irq_event;

	assign setup  = apb_req.psel && !apb_req.penable;
	assign wr_acc = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite;
	assign mapped = apb_req.paddr == REG_CTRL || apb_req.paddr == REG_STATE ||
		apb_req.paddr == REG_IRQ_ST || apb_req.paddr == REG_IRQ_MK;
	assign force_dump = wr_acc && apb_req.paddr == REG_CTRL &&
		apb_req.pwdata[CTRL_FORCE_BIT] && dump_request_n_q;
	assign irq_event[IRQ_FAULT_BIT] = seq_request;
	assign irq_event[IRQ_DONE_BIT]  = !dump_request_n_q && counter_q == CNT_LAST;

	// No wait state: data is registered in the setup cycle.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			apb_rsp <= '0;
		end else begin
			apb_rsp.pready  <= setup;
			apb_rsp.pslverr <= setup && !mapped;
			apb_rsp.prdata  <= '0;
			if (setup && !apb_req.pwrite) begin
				unique case (apb_req.paddr)
					REG_STATE:  apb_rsp.prdata <= {24'h0, good_s, power_good_indicator_n,
						dump_request_n_q, counter_q, state_q};
					REG_IRQ_ST: apb_rsp.prdata <= {30'h0, irq_status_q};
					REG_IRQ_MK: apb_rsp.prdata <= {30'h0, irq_mask_q};
					default:    apb_rsp.prdata <= '0;
				endcase
			end
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			irq_mask_q <= IRQ_MASK_RST;
		end else if (wr_acc && apb_req.paddr == REG_IRQ_MK) begin
			irq_mask_q <= apb_req.pwdata[1:0];
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			irq_status_q <= 2'h0;
		end else if (wr_acc && apb_req.paddr == REG_IRQ_ST) begin
			irq_status_q <= (irq_status_q & ~apb_req.pwdata[1:0]) | irq_event;
		end else begin
			irq_status_q <= irq_status_q | irq_event;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status_q & irq_mask_q);
		end
	end

	// -----------------------------------------------------------------
	// Assertions
	// -----------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);

	property p_dump_clock_period;
		$rose(dump_clock) |-> ##40 $rose(dump_clock);
	endproperty
	a_dump_clock_period: assert property (p_dump_clock_period)
		else $error("dump clock period is not 40 cycles");

	property p_hold_three;
		dump_request_n_q && $past(dump_request_n_q) |-> counter_q == CNT_HOLD;
	endproperty
	a_hold_three: assert property (p_hold_three)
		else $error("counter not held at 3 while idle");

	property p_step_on_tick;
		!dump_request_n_q && !dump_tick |=> $stable(counter_q);
	endproperty
	a_step_on_tick: assert property (p_step_on_tick)
		else $error("counter moved without a dump clock edge");

	property p_release_at_two;
		counter_q == CNT_LAST && !seq_request && !force_dump |=> dump_request_n_q;
	endproperty
	a_release_at_two: assert property (p_release_at_two)
		else $error("request not released at count 2");

	property p_six_slots;
		$rose(counter_q == CNT_FIRST) |-> ##240 counter_q == CNT_LAST;
	endproperty
	a_six_slots: assert property (p_six_slots)
		else $error("dump did not span six dump clocks");

	property p_strobe_msb;
		capture_strobe == counter_q[2];
	endproperty
	a_strobe_msb: assert property (p_strobe_msb)
		else $error("capture strobe differs from counter msb");

	property p_fault_request;
		state_q == S_MONITOR && !good_s |=> !dump_request_n_q && power_good_indicator_n;
	endproperty
	a_fault_request: assert property (p_fault_request)
		else $error("window loss did not request a dump");

	property p_startup_off;
		state_q == S_WAIT_READY || state_q == S_DELAY |=> power_good_indicator_n;
	endproperty
	a_startup_off: assert property (p_startup_off)
		else $error("indicator on during start-up");

	property p_delay_done;
		$past(state_q) == S_DELAY && state_q == S_WAIT_GOOD |-> $past(timer_done);
	endproperty
	a_delay_done: assert property (p_delay_done)
		else $error("start-up delay cut short");

	property p_idle_bus;
		counter_q == CNT_HOLD |-> status_bus == '0;
	endproperty
	a_idle_bus: assert property (p_idle_bus)
		else $error("status bus not quiet while idle");

	property p_irq_level;
		|(irq_status_q & irq_mask_q) |=> irq;
	endproperty
	a_irq_level: assert property (p_irq_level)
		else $error("interrupt not raised for unmasked status");

	// The bus is registered, so the first slot shows the flags of the cycle before.
	property p_first_slot;
		counter_q == CNT_FIRST |-> status_bus == {$past(flags_s[18]), $past(flags_s[12]),
			$past(flags_s[6]), $past(flags_s[0])};
	endproperty
	a_first_slot: assert property (p_first_slot)
		else $error("first dump slot carries the wrong flags");

	property p_strobe_after_request;
		$fell(dump_request_n_q) |-> ##[1:40] capture_strobe;
	endproperty
	a_strobe_after_request: assert property (p_strobe_after_request)
		else $error("capture strobe did not follow a dump request");

	c_full_dump: cover property ($rose(capture_strobe) ##[1:300] counter_q == CNT_LAST);
	c_forced:    cover property (force_dump);
	c_fault:     cover property (seq_request);
	c_irq:       cover property ($rose(irq));

endmodule // supply_fault_status_dump

// ===== core/dump_pkg.sv
// Shared constants, states and carriers for the supply fault status dump block.
package dump_pkg;

	// -----------------------------------------------------------------
	// Clocking and timing
	// -----------------------------------------------------------------
	localparam int unsigned CLK_HZ         = 10_000_000;
	localparam int unsigned DUMP_HZ        = 250_000;
	localparam int unsigned DUMP_HALF_CYC  = CLK_HZ / (2 * DUMP_HZ);
	localparam int unsigned START_DELAY_US = 15_360;
	localparam int unsigned START_DELAY_CYC = (START_DELAY_US * (CLK_HZ / 1_000_000));
	localparam int unsigned TIMER_W        = 18;

	// Window trip points of the monitored supply, in millivolts.
	localparam int unsigned TRIP_LOW_MV  = 2000;
	localparam int unsigned TRIP_HIGH_MV = 3000;

	// -----------------------------------------------------------------
	// Dump counter and status bus
	// -----------------------------------------------------------------
	localparam logic [2:0] CNT_HOLD  = 3'h3;
	localparam logic [2:0] CNT_FIRST = 3'h4;
	localparam logic [2:0] CNT_LAST  = 3'h2;
	localparam int unsigned N_CHAN   = 12;
	localparam int unsigned N_FLAGS  = 2 * N_CHAN;
	localparam int unsigned BUS_W    = 4;
	localparam int unsigned DUMP_SLOTS = N_FLAGS / BUS_W;

	// -----------------------------------------------------------------
	// Register map (byte addresses) and fields
	// -----------------------------------------------------------------
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATE  = 8'h04;
	localparam logic [7:0] REG_IRQ_ST = 8'h08;
	localparam logic [7:0] REG_IRQ_MK = 8'h0c;
	localparam int unsigned CTRL_FORCE_BIT = 0;
	localparam int unsigned IRQ_FAULT_BIT  = 0;
	localparam int unsigned IRQ_DONE_BIT   = 1;
	localparam logic [1:0] IRQ_MASK_RST    = 2'h0;

	typedef enum logic [1:0] {
		S_WAIT_READY = 2'b00,
		S_DELAY      = 2'b01,
		S_WAIT_GOOD  = 2'b11,
		S_MONITOR    = 2'b10
	} seq_state_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} apb_rsp_t;

endpackage

// ===== core/sync_2ff.sv
// Two flip-flop synchroniser for a group of level inputs from another domain.
module sync_2ff #(
	parameter int unsigned WIDTH = 1
) (
	input  wire logic             clock,
	input  wire logic             arst_n,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule // sync_2ff

// ===== core/delay_timer.sv
// One-shot down-counting timer: done pulses once when a started count expires.
module delay_timer #(
	parameter int unsigned WIDTH = 18
) (
	input  wire logic             clock,
	input  wire logic             arst_n,
	input  wire logic             start,
	input  wire logic [WIDTH-1:0] load,
	output logic                  done
);

	logic [WIDTH-1:0] count_q;
	logic             run_q;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			count_q <= '0;
			run_q   <= 1'b0;
			done    <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				count_q <= load;
				run_q   <= 1'b1;
			end else if (run_q) begin
				if (count_q <= WIDTH'(1)) begin
					run_q <= 1'b0;
					done  <= 1'b1;
				end else begin
					count_q <= count_q - WIDTH'(1);
				end
			end
		end
	end

endmodule // delay_timer

// ===== dv/dump_capture.sv
// Behavioural capturing logic that takes in one status dump per strobe rise.
module dump_capture (
	input  wire logic                         clock,
	input  wire logic                         arst_n,
	input  wire logic                         dump_clock,
	input  wire logic                         capture_strobe,
	input  wire logic [dump_pkg::BUS_W-1:0]   status_bus,
	output logic      [dump_pkg::N_FLAGS-1:0] captured,
	output int                                dumps,
	output int                                hi_n
);
	timeunit 1ns;
	timeprecision 1ns;
	import dump_pkg::*;

	// ---------------------------------------------------------------
	// Capture
	// ---------------------------------------------------------------
	logic strobe_q;
	logic dclk_q;
	logic active_q;
	int   slot_q;

	// The dump clock is sampled, so a falling edge is seen one cycle late, mid slot.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			strobe_q <= 1'b0;
			dclk_q   <= 1'b0;
			active_q <= 1'b0;
			slot_q   <= 0;
			captured <= '0;
			dumps    <= 0;
			hi_n     <= 0;
		end else begin
			strobe_q <= capture_strobe;
			dclk_q   <= dump_clock;
			if (capture_strobe)
				hi_n <= strobe_q ? hi_n + 1 : 1;
			if (capture_strobe && !strobe_q) begin
				active_q <= 1'b1;
				slot_q   <= 0;
			end else if (active_q && dclk_q && !dump_clock) begin
				for (int g = 0; g < BUS_W; g++)
					captured[DUMP_SLOTS*g+slot_q] <= status_bus[g];
				slot_q <= slot_q + 1;
				if (slot_q == DUMP_SLOTS - 1) begin
					active_q <= 1'b0;
					dumps    <= dumps + 1;
				end
			end
		end
	end
endmodule // dump_capture

// ===== dv/tb_supply_fault_status_dump.sv
// Self-checking bench for the supply fault status dump block.
module tb_supply_fault_status_dump;
	timeunit 1ns;
	timeprecision 1ns;
	import dump_pkg::*;

	// ---------------------------------------------------------------
	// Signals
	// ---------------------------------------------------------------
	localparam int SD = 50;
	typedef struct packed {
		logic [N_FLAGS-1:0] flags;
		logic [N_FLAGS-1:0] want;
	} row_t;
	row_t rows [4] = '{
		'{24'h000001, 24'h000001},
		'{24'h800000, 24'h800000},
		'{24'h924924, 24'h924924},
		'{24'hffffff, 24'hffffff}
	};
	logic               clock = 1'b0;
	logic               arst_n;
	apb_req_t           apb_req;
	apb_rsp_t           apb_rsp;
	logic               irq;
	logic               analog_ready;
	logic               window_good;
	logic [N_FLAGS-1:0] monitor_flags;
	logic               power_good_indicator_n;
	logic               dump_clock;
	logic [BUS_W-1:0]   status_bus;
	logic               capture_strobe;
	logic [N_FLAGS-1:0] captured;
	int                 dumps;
	int                 hi_n;
	int                 err_total = 0;
	int                 checks_done = 0;
	int                 want_dumps;
	int                 n;
	logic [31:0]        q;
	logic               e;

	always #50 clock = ~clock;

	supply_fault_status_dump #(.START_DELAY(SD)) dut (
		.clock(clock), .arst_n(arst_n), .apb_req(apb_req), .apb_rsp(apb_rsp),
		.irq(irq), .analog_ready(analog_ready), .window_good(window_good),
		.monitor_flags(monitor_flags),
		.power_good_indicator_n(power_good_indicator_n), .dump_clock(dump_clock),
		.status_bus(status_bus), .capture_strobe(capture_strobe));

	dump_capture cap (
		.clock(clock), .arst_n(arst_n), .dump_clock(dump_clock),
		.capture_strobe(capture_strobe), .status_bus(status_bus),
		.captured(captured), .dumps(dumps), .hi_n(hi_n));

	// ---------------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------------
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clock);
		apb_req <= '{1'b1, 1'b0, wr, a, d};
		@(posedge clock);
		apb_req.penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clock);
			k++;
		end while (apb_rsp.pready !== 1'b1 && k < 50);
		if (apb_rsp.pready !== 1'b1) begin
			err_total++;
			test_done();
		end
		q = apb_rsp.prdata;
		e = apb_rsp.pslverr;
		apb_req <= '0;
	endtask

	// Mode 0 waits for the indicator to come on, mode 1 for the next captured dump.
	task automatic wait_for(input int what);
		n = 0;
		while (!(what == 0 ? power_good_indicator_n === 1'b0 : dumps == want_dumps)) begin
			@(posedge clock);
			n++;
			if (n > 3000) begin
				err_total++;
				test_done();
			end
		end
	endtask

	// ---------------------------------------------------------------
	// Sequence
	// ---------------------------------------------------------------
	initial begin
		arst_n = 1'b0;
		apb_req = '0;
		analog_ready = 1'b0;
		window_good = 1'b1;
		monitor_flags = '0;
		repeat (2) @(posedge clock);
		arst_n <= 1'b1;
		@(posedge clock);
		chk(32'(power_good_indicator_n), 1);
		chk(32'({capture_strobe, status_bus}), 0);
		apb(1'b0, REG_STATE, 0);
		chk(32'(q[5:2]), 32'hb);
		repeat (SD + 20) @(posedge clock);
		chk(32'(power_good_indicator_n), 1);
		analog_ready <= 1'b1;
		wait_for(0);
		chk(32'(n >= SD && n <= SD + 20), 1);
		for (int i = 0; i < 4; i++) begin
			@(posedge clock);
			monitor_flags <= rows[i].flags;
			window_good <= 1'b1;
			wait_for(0);
			@(posedge clock);
			window_good <= 1'b0;
			want_dumps = i + 1;
			wait_for(1);
			chk(32'(captured), 32'(rows[i].want));
			chk(32'(hi_n), 160);
			chk(32'(power_good_indicator_n), 1);
			// The last slot is still out when the capture ends; a request before
			// the request is released at count 2 would be ignored.
			repeat (40) @(posedge clock);
		end
		chk(32'(irq), 0);
		apb(1'b1, REG_IRQ_MK, 32'h3);
		repeat (3) @(posedge clock);
		chk(32'(irq), 1);
		apb(1'b0, REG_IRQ_ST, 0);
		chk(q, 32'h3);
		apb(1'b1, REG_IRQ_ST, 32'h3);
		repeat (3) @(posedge clock);
		chk(32'(irq), 0);
		apb(1'b0, 8'h10, 0);
		chk(32'(e), 1);
		chk(q, 0);
		apb(1'b0, REG_STATE, 0);
		chk(32'(q[5:2]), 32'hb);
		chk(32'({capture_strobe, status_bus}), 0);
		monitor_flags <= 24'h5a5a5a;
		want_dumps = 5;
		apb(1'b1, REG_CTRL, 32'h1);
		apb(1'b1, REG_CTRL, 32'h1);
		wait_for(1);
		chk(32'(captured), 32'h5a5a5a);
		repeat (400) @(posedge clock);
		chk(32'(dumps), 5);
		// Reset in the middle of a forced dump must silence the link at once.
		apb(1'b1, REG_CTRL, 32'h1);
		repeat (60) @(posedge clock);
		chk(32'(capture_strobe), 1);
		arst_n <= 1'b0;
		@(posedge clock);
		chk(32'({dump_clock, capture_strobe, status_bus}), 0);
		chk(32'(power_good_indicator_n), 1);
		@(posedge clock);
		arst_n <= 1'b1;
		@(posedge clock);
		chk(32'({capture_strobe, status_bus}), 0);
		chk(32'(dumps), 0);
		apb(1'b0, REG_STATE, 0);
		chk(32'(q[5:2]), 32'hb);
		test_done();
	end
endmodule // tb_supply_fault_status_dump
